// file: common/sse_pkg.sv
// package for the subtract and special-page execution datapath
// assumes one core clock, synchronous active-high reset, decoded op strobes
// Functional notes
// (RULE1) Register minus accumulator with borrow computes reg + ~acc + carry, sets flags, one cycle.
// (RULE2) Destination bit 0 sends a register-operand subtract result to the accumulator, 1 to the file register.
// (RULE3) Immediate minus accumulator with borrow computes imm + ~acc + carry into the accumulator, sets flags, one cycle.
// (RULE4) Carry means no borrow and zero is set when the 8-bit result is zero.
// (RULE5) Register minus accumulator computes reg - acc in two's complement, routed by the destination bit, one cycle.
// (RULE6) Store to special page copies the accumulator into page entry 0 to 21, flags and accumulator kept.
// (RULE7) Load from special page copies page entry 0 to 21 into the accumulator, flags kept; the code drops it if a subtract to acc follows next cycle.
// (RULE8) Digit carry is set when no borrow passes from bit 3 into bit 4.
package sse_pkg;
  localparam int SSE_DATA_W = 8;
  localparam int SSE_SEL_W = 5;
  localparam logic [4:0] SSE_SEL_MAX = 5'h15;
  localparam logic [6:0] SSE_REG_MAX = 7'h7F;
  localparam logic [7:0] SSE_ACC_RST = 8'h00;
  localparam logic SSE_FLAG_RST = 1'b0;
  localparam logic SSE_DEST_ACC = 1'b0;
  localparam logic SSE_DEST_REG = 1'b1;
  localparam int SSE_EXEC_CYCLES = 1;
  typedef enum logic [2:0] {
    SSE_OP_NONE, SSE_OP_SBC_REG, SSE_OP_SBC_IMM, SSE_OP_SUB_REG,
    SSE_OP_ST_PAGE, SSE_OP_LD_PAGE
  } sse_op_e;
endpackage

// file: logic/sse_page_mem.sv
// special-page register store, 22 entries of 8 bits
// assumes select already range-checked by the caller
`timescale 1ns/100ps
module sse_page_mem
  import sse_pkg::*;
(
  // clock
  input wire logic clk,
  input wire logic ce,
  // access
  input wire logic wr_en,
  input wire logic [SSE_SEL_W-1:0] sel,
  input wire logic [SSE_DATA_W-1:0] wr_data,
  output logic [SSE_DATA_W-1:0] rd_data
);
  logic [SSE_DATA_W-1:0] mem [0:21];

  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem[sel] <= wr_data;
    end
  end

  // registered read, combined with write for same-cycle view not needed
  always_ff @(posedge clk) begin
    if (ce) begin
      rd_data <= mem[sel];
    end
  end
endmodule

// file: logic/sse_exec.sv
// execution datapath: three subtract forms and special-page transfers
// assumes decode gives one op per cycle, reg_data valid with the op
`timescale 1ns/100ps
module sse_exec
  import sse_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // decoded instruction
  input wire logic sub_reg_acc_borrow_op,
  input wire logic sub_imm_acc_borrow_op,
  input wire logic sub_reg_acc_op,
  input wire logic store_special_page_op,
  input wire logic load_special_page_op,
  input wire logic dest_sel,
  input wire logic [6:0] reg_addr,
  input wire logic [SSE_DATA_W-1:0] reg_data,
  input wire logic [SSE_DATA_W-1:0] imm_data,
  input wire logic [SSE_SEL_W-1:0] page_sel,
  // file register write-back
  output logic reg_wr,
  output logic [6:0] reg_wr_addr,
  output logic [SSE_DATA_W-1:0] reg_wr_data,
  // architectural state
  output logic [SSE_DATA_W-1:0] accumulator,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic zero_flag,
  output logic [SSE_DATA_W-1:0] page_rd_data
);
  logic is_sub;
  logic sel_ok;
  logic [SSE_DATA_W-1:0] opnd;
  logic cin;
  logic [4:0] lo_sum;
  logic [4:0] hi_sum;
  logic [SSE_DATA_W-1:0] result;
  logic ld_pend;
  logic [SSE_DATA_W-1:0] mem_rd;

  assign is_sub = sub_reg_acc_borrow_op | sub_imm_acc_borrow_op | sub_reg_acc_op;
  assign sel_ok = page_sel <= SSE_SEL_MAX;

  // (RULE1) operand and carry-in
  always_comb begin
    opnd = sub_imm_acc_borrow_op ? imm_data : reg_data;
    cin = sub_reg_acc_op ? 1'b1 : carry_flag;
  end

  // (RULE8) nibble adders give digit carry
  assign lo_sum = {1'b0, opnd[3:0]} + {1'b0, ~accumulator[3:0]} + {4'h0, cin};
  assign hi_sum = {1'b0, opnd[7:4]} + {1'b0, ~accumulator[7:4]} + {4'h0, lo_sum[4]};
  assign result = {hi_sum[3:0], lo_sum[3:0]};

  // (RULE4) flags only on subtracts
  always_ff @(posedge clk) begin
    if (rst) begin
      carry_flag <= SSE_FLAG_RST;
      digit_carry_flag <= SSE_FLAG_RST;
      zero_flag <= SSE_FLAG_RST;
    end else if (ce && is_sub) begin
      carry_flag <= hi_sum[4];
      digit_carry_flag <= lo_sum[4];
      zero_flag <= (result == 8'h00);
    end
  end

  // (RULE2) destination routing to the accumulator
  always_ff @(posedge clk) begin
    if (rst) begin
      accumulator <= SSE_ACC_RST;
    end else if (ce) begin
      // (RULE3) immediate always to acc
      if (sub_imm_acc_borrow_op) begin
        accumulator <= result;
      end else if ((sub_reg_acc_borrow_op || sub_reg_acc_op) && dest_sel == SSE_DEST_ACC) begin
        accumulator <= result;
      end else if (ld_pend) begin
        accumulator <= mem_rd;
      end
    end
  end

  // (RULE5) write-back to the file register
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_wr <= 1'b0;
      reg_wr_addr <= 7'h00;
      reg_wr_data <= 8'h00;
    end else if (ce) begin
      reg_wr <= (sub_reg_acc_borrow_op || sub_reg_acc_op) && dest_sel == SSE_DEST_REG;
      reg_wr_addr <= reg_addr;
      reg_wr_data <= result;
    end
  end

  // (RULE7) page read lands in the accumulator on the second edge after the load op, unless a subtract writes the accumulator on that edge
  always_ff @(posedge clk) begin
    if (rst) begin
      ld_pend <= 1'b0;
    end else if (ce) begin
      ld_pend <= load_special_page_op && sel_ok;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      page_rd_data <= 8'h00;
    end else if (ce && ld_pend) begin
      page_rd_data <= mem_rd;
    end
  end

  // (RULE6) page write from the accumulator
  sse_page_mem u_mem (
    .clk(clk),
    .ce(ce),
    .wr_en(store_special_page_op && sel_ok),
    .sel(sel_ok ? page_sel : 5'h00),
    .wr_data(accumulator),
    .rd_data(mem_rd)
  );

  property p_sbc_imm;
    @(posedge clk) disable iff (rst)
      (ce && sub_imm_acc_borrow_op)
      |=> accumulator == 8'($past(imm_data) + ~$past(accumulator) + 8'($past(carry_flag)));
  endproperty
  a_sbc_imm: assert property (p_sbc_imm) else $error("imm borrow result wrong"); // RULE3

  property p_sbc_reg;
    @(posedge clk) disable iff (rst)
      (ce && sub_reg_acc_borrow_op && dest_sel)
      |=> reg_wr && reg_wr_data == 8'($past(reg_data) + ~$past(accumulator)
          + 8'($past(carry_flag)));
  endproperty
  a_sbc_reg: assert property (p_sbc_reg) else $error("reg borrow result wrong"); // RULE1

  property p_dest;
    @(posedge clk) disable iff (rst)
      (ce && sub_reg_acc_op && !dest_sel)
      |=> !reg_wr && accumulator == 8'($past(reg_data) - $past(accumulator));
  endproperty
  a_dest: assert property (p_dest) else $error("destination routing wrong"); // RULE2

  property p_carry;
    @(posedge clk) disable iff (rst)
      (ce && sub_reg_acc_op) |=> carry_flag == ($past(reg_data) >= $past(accumulator));
  endproperty
  a_carry: assert property (p_carry) else $error("carry not no-borrow"); // RULE4

  property p_sub;
    @(posedge clk) disable iff (rst)
      (ce && sub_reg_acc_op && dest_sel)
      |=> reg_wr_data == 8'($past(reg_data) - $past(accumulator))
      && zero_flag == (reg_wr_data == 8'h00);
  endproperty
  a_sub: assert property (p_sub) else $error("plain subtract wrong"); // RULE5

  property p_store_keep;
    @(posedge clk) disable iff (rst)
      (ce && store_special_page_op) |=> $stable(accumulator) && $stable(carry_flag)
      && $stable(zero_flag) && $stable(digit_carry_flag);
  endproperty
  a_store_keep: assert property (p_store_keep) else $error("store altered state"); // RULE6

  property p_load_flags;
    @(posedge clk) disable iff (rst)
      (ce && load_special_page_op) |=> $stable(carry_flag) && $stable(digit_carry_flag)
      && $stable(zero_flag);
  endproperty
  a_load_flags: assert property (p_load_flags) else $error("load altered flags"); // RULE7

  property p_dc;
    @(posedge clk) disable iff (rst)
      (ce && sub_reg_acc_op)
      |=> digit_carry_flag == ($past(reg_data[3:0]) >= $past(accumulator[3:0]));
  endproperty
  a_dc: assert property (p_dc) else $error("digit carry wrong"); // RULE8

  c_sbc: cover property (@(posedge clk) disable iff (rst) ce && sub_reg_acc_borrow_op && carry_flag);
  c_imm: cover property (@(posedge clk) disable iff (rst) ce && sub_imm_acc_borrow_op);
  c_st_ld: cover property (@(posedge clk) disable iff (rst)
    ce && store_special_page_op ##1 ce && load_special_page_op);
  c_wb: cover property (@(posedge clk) disable iff (rst) reg_wr);
  c_hold: cover property (@(posedge clk) disable iff (rst) !ce && sub_reg_acc_op);

  property p_sbc_acc;
    @(posedge clk) disable iff (rst)
      (ce && sub_reg_acc_borrow_op && !dest_sel)
      |=> !reg_wr && accumulator == 8'($past(reg_data) + ~$past(accumulator)
          + 8'($past(carry_flag)));
  endproperty
  a_sbc_acc: assert property (p_sbc_acc) else $error("reg borrow to acc wrong"); // RULE1

  property p_wb_addr;
    @(posedge clk) disable iff (rst)
      (ce && (sub_reg_acc_borrow_op || sub_reg_acc_op) && dest_sel)
      |=> reg_wr && reg_wr_addr == $past(reg_addr);
  endproperty
  a_wb_addr: assert property (p_wb_addr) else $error("write-back address wrong"); // RULE2

  property p_imm_flags;
    @(posedge clk) disable iff (rst)
      (ce && sub_imm_acc_borrow_op)
      |=> carry_flag == (({1'b0, $past(imm_data)} + 9'($past(carry_flag)))
          > {1'b0, $past(accumulator)})
      && zero_flag == (accumulator == 8'h00);
  endproperty
  a_imm_flags: assert property (p_imm_flags) else $error("imm borrow flags wrong"); // RULE4

  property p_imm_dc;
    @(posedge clk) disable iff (rst)
      (ce && sub_imm_acc_borrow_op)
      |=> digit_carry_flag == (({1'b0, $past(imm_data[3:0])} + 5'($past(carry_flag)))
          > {1'b0, $past(accumulator[3:0])});
  endproperty
  a_imm_dc: assert property (p_imm_dc) else $error("imm digit carry wrong"); // RULE8

  property p_st_ld;
    @(posedge clk) disable iff (rst)
      (ce && store_special_page_op && sel_ok)
      ##1 (ce && load_special_page_op && page_sel == $past(page_sel)) ##1 ce
      |=> page_rd_data == $past(accumulator, 3);
  endproperty
  a_st_ld: assert property (p_st_ld) else $error("page entry not read back"); // RULE6

  property p_freeze;
    @(posedge clk) disable iff (rst)
      !ce |=> $stable(accumulator) && $stable(carry_flag) && $stable(digit_carry_flag)
      && $stable(zero_flag) && $stable(reg_wr) && $stable(reg_wr_data)
      && $stable(page_rd_data);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while ce low");
endmodule

// file: tb/tb_top.sv
// self-checking bench for the subtract and special-page datapath
// assumes sse_pkg and sse_exec are compiled first
`timescale 1ns/100ps
module tb_top;
  import sse_pkg::*;
  logic clk = 0, rst = 1, ce = 1, d = 0;
  logic [4:0] opv = 0, ps = 0;
  logic [6:0] ra = 0, wa;
  logic [7:0] rd = 0, imm = 0, wd, acc, prd, m_acc;
  logic reg_wr, cf, dcf, zf, m_c, m_dc, m_z;
  logic [7:0] page [0:21];
  int mismatches = 0, num_checks = 0;
  always #5 clk = ~clk;
  sse_exec u_sse_exec (.clk(clk), .rst(rst), .ce(ce), .sub_reg_acc_borrow_op(opv[0]),
    .sub_imm_acc_borrow_op(opv[1]), .sub_reg_acc_op(opv[2]), .store_special_page_op(opv[3]),
    .load_special_page_op(opv[4]), .dest_sel(d), .reg_addr(ra), .reg_data(rd),
    .imm_data(imm), .page_sel(ps), .reg_wr(reg_wr), .reg_wr_addr(wa), .reg_wr_data(wd),
    .accumulator(acc), .carry_flag(cf), .digit_carry_flag(dcf), .zero_flag(zf),
    .page_rd_data(prd));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic test_done;
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // k: 0 reg borrow, 1 imm borrow, 2 reg plain, 3 store, 4 load
  task automatic op(input int k, input logic dv, input logic [7:0] a, input logic [4:0] s);
    logic [8:0] sum;
    logic [4:0] lo;
    logic cin, wr;
    cin = (k == 2) ? 1'b1 : m_c;
    sum = {1'b0, a} + {1'b0, ~m_acc} + 9'(cin);
    lo = {1'b0, a[3:0]} + {1'b0, ~m_acc[3:0]} + 5'(cin);
    wr = (k == 0 || k == 2) && dv;
    @(posedge clk);
    opv <= 5'(1 << k);
    d <= dv;
    rd <= a;
    imm <= a;
    ps <= s;
    ra <= {2'b11, s};
    @(posedge clk);
    opv <= 5'h00;
    if (k == 4) @(posedge clk);
    @(negedge clk);
    if (k < 3) begin
      if (!wr) m_acc = sum[7:0];
      m_c = sum[8];
      m_dc = lo[4];
      m_z = (sum[7:0] == 8'h00);
    end
    if (k == 3 && s <= SSE_SEL_MAX) page[s] = m_acc;
    if (k == 4 && s <= SSE_SEL_MAX) m_acc = page[s];
    chk(acc, m_acc, "acc");
    chk({5'h00, cf, dcf, zf}, {5'h00, m_c, m_dc, m_z}, "flags");
    chk({7'h00, reg_wr}, {7'h00, wr}, "reg_wr");
    if (wr) chk(wd, sum[7:0], "wb data");
    if (wr) chk({1'b0, wa}, {3'b011, s}, "wb addr");
    if (k == 4 && s <= SSE_SEL_MAX) chk(prd, m_acc, "page rd");
  endtask
  task automatic t_reset;
    chk(acc, 8'h00, "rst acc");
    chk({4'h0, cf, dcf, zf, reg_wr}, 8'h00, "rst flags");
    chk(prd, 8'h00, "rst page");
    m_acc = 8'h00;
    {m_c, m_dc, m_z} = 3'b000;
  endtask
  task automatic t_imm;
    logic [7:0] v [6] = '{8'h07, 8'h05, 8'h05, 8'h06, 8'h10, 8'hFF};
    foreach (v[i]) op(1, 1'b1, v[i], 5'h00);
  endtask
  task automatic t_reg;
    logic [7:0] v [4] = '{8'h05, 8'h06, 8'h80, 8'h00};
    foreach (v[i]) begin
      op(0, i[0], v[i], 5'(i));
      op(2, ~i[0], v[i], 5'h1F);
    end
  endtask
  task automatic t_page;
    op(3, 1'b0, 8'h00, 5'h00);
    op(1, 1'b0, 8'h3C, 5'h00);
    op(3, 1'b0, 8'h00, 5'h15);
    op(3, 1'b0, 8'h00, 5'h16);
    op(4, 1'b0, 8'h00, 5'h00);
    op(4, 1'b0, 8'h00, 5'h16);
    op(4, 1'b0, 8'h00, 5'h15);
  endtask
  task automatic t_burst;
    op(1, 1'b0, 8'hA5, 5'h00);
    @(posedge clk);
    opv <= 5'h08;
    ps <= 5'h05;
    @(posedge clk);
    opv <= 5'h10;
    @(posedge clk);
    opv <= 5'h00;
    @(posedge clk);
    @(negedge clk);
    page[5] = m_acc;
    chk(prd, m_acc, "burst page");
    chk(acc, m_acc, "burst acc");
    chk({5'h00, cf, dcf, zf}, {5'h00, m_c, m_dc, m_z}, "burst flags");
  endtask
  task automatic t_ce;
    @(posedge clk);
    ce <= 1'b0;
    opv <= 5'h04;
    d <= 1'b0;
    rd <= 8'h99;
    repeat (2) @(posedge clk);
    opv <= 5'h00;
    @(posedge clk);
    ce <= 1'b1;
    @(negedge clk);
    chk(acc, m_acc, "ce acc");
    chk({5'h00, cf, dcf, zf}, {5'h00, m_c, m_dc, m_z}, "ce flags");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_reset;
    t_imm;
    t_reg;
    t_page;
    t_burst;
    t_ce;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_reset;
    test_done;
  end
  initial begin
    #20000;
    mismatches++;
    test_done;
  end
endmodule
